// ---- rtl/eeb_slot_ctrl.sv ----
// host side controller of one expansion slot
// Overview of operation
// (RL1) byte_width_qualifier_n is low for a byte access, high for halfword or word, don't-care in DMA.
// (RL2) while the card holds ready_n low the host does not end the cycle.
// (RL3) the card asserts ready_n soon after the strobe falls and keeps it until it can finish.
// (RL4) the card requests a DMA transfer by raising transfer_request.
// (RL5) the host marks a DMA cycle in service by driving transfer_acknowledge_n low.
// (RL6) the host drives last_transfer_flag high through the final cycle of a DMA block.
// (RL7) read_not_write is high all through a read and low all through a write.
// (RL8) write_strobe_n pulses low for the data phase of every write.
// (RL9) read_strobe_n pulses low for the data phase of every read.
// (RL10) extended_space_select_n is low for the whole of each extended-space access.
// (RL11) the upper sixteen data lines are driven except during DMA reads and extended reads.
// (RL12) the card drives the upper data lines only during extended and DMA reads.
// (RL13) slow cycles keep select 427 ns and strobe 240 ns, fast ones 175 ns and 115 ns at least.
// (RL14) address and width qualifier are stable before select falls until after it rises.
// (RL15) the card should resample bus signals on its own clock.
// (RL16) DMA signals exist only on slots zero and one.
// (RL17) after ready_n rises the strobe rises first, then the select.
`timescale 1ns/1ps
`default_nettype none
`include "eeb_consts.svh"
module eeb_slot_ctrl #(
  parameter int SLOT = 0
) (
  input wire logic ref_clk, // 20 MHz system clock
  input wire logic rstn, // synchronous reset, active low
  input wire logic req_valid, // user access request
  output logic req_ready, // controller idle, request taken
  input wire logic req_dma, // 1 = DMA cycle, 0 = extended space
  input wire logic req_read, // 1 = read
  input wire logic req_byte, // 1 = byte access
  input wire logic req_fast, // 1 = fast cycle type
  input wire logic req_last, // last DMA cycle of block
  input wire logic [23:0] req_addr, // access address
  input wire logic [31:0] req_wdata, // write data
  output logic rsp_valid, // one-cycle completion pulse
  output logic [31:0] rsp_rdata, // read data
  output logic dma_pending, // synchronised DMA request
  output logic [23:0] latched_address, // slot address
  output logic byte_width_qualifier_n, // low for byte access
  input wire logic [31:0] buffered_data_i, // data lines in
  output logic [31:0] buffered_data_o, // data lines out
  output logic [1:0] buffered_data_oe, // drive enable low / high halves
  output logic read_not_write, // direction
  output logic write_strobe_n, // write strobe
  output logic read_strobe_n, // read strobe
  output logic extended_space_select_n, // extended select
  input wire logic ready_n, // card wait line
  input wire logic transfer_request, // card DMA request
  output logic transfer_acknowledge_n, // DMA acknowledge
  output logic last_transfer_flag, // terminal count
  output logic host_system_clock // reference clock out, 1/2 rate
);
  import eeb_pkg::*;
  localparam logic DMA_OK = (SLOT == 0) || (SLOT == 1); // [RL16]
  // refuse slot numbers beyond the eight a backplane carries
  if (SLOT < 0 || SLOT > 7) begin : g_slot_check
    $error("eeb_slot_ctrl: SLOT out of range");
  end
  localparam logic [3:0] SLOW_STB = 4'(`EEB_SLOW_STB_CYC);
  localparam logic [3:0] FAST_STB = 4'(`EEB_FAST_STB_CYC);
  localparam logic [3:0] SLOW_LEAD = 4'(`EEB_SLOW_LEAD_CYC);
  localparam logic [3:0] FAST_LEAD = 4'(`EEB_FAST_LEAD_CYC);
  localparam logic [3:0] SLOW_SEL = 4'(`EEB_SLOW_SEL_CYC);
  localparam logic [3:0] FAST_SEL = 4'(`EEB_FAST_SEL_CYC);
  localparam logic [3:0] SETUP = 4'(`EEB_SETUP_CYC);
  localparam logic [3:0] HOLD = 4'(`EEB_HOLD_CYC);

  eeb_state_t state_q, state_d;
  eeb_kind_t kind_q;
  eeb_speed_t speed_q;
  logic read_q, last_q;
  logic [3:0] sel_cnt_q;
  logic ready_n_s, treq_s, cnt_done, cnt_load;
  logic [3:0] cnt_value;
  logic sel_n_q, wr_n_q, rd_n_q, ack_n_q, tc_q, clk_q, rsp_q;
  logic [1:0] oe_q;
  logic [23:0] addr_q;
  logic bw_n_q, rnw_q;
  logic [31:0] wdata_q, rdata_q;
  logic [31:0] data_s;
  logic ready_q;

  // pin inputs crossed into ref_clk
  eeb_sync #(.W(2), .INIT(2'b01)) u_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .d({transfer_request, ready_n}),
    .q({treq_s, ready_n_s})
  );

  // data lines crossed as well; the two-cycle lag matches the lag of the
  // wait line, so data seen with the wait released is data of the same moment
  eeb_sync #(.W(32), .INIT(32'h0)) u_data_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .d(buffered_data_i),
    .q(data_s)
  );

  // phase timer
  eeb_counter #(.W(4)) u_cnt (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .load(cnt_load),
    .value(cnt_value),
    .done(cnt_done)
  );

  function automatic logic [3:0] pick(input eeb_speed_t sp, input logic [3:0] s, input logic [3:0] f);
    pick = (sp == EEB_SPEED_FAST) ? f : s;
  endfunction : pick

  // request acceptance and sequencing decode
  wire logic take = (state_q == EEB_IDLE) && req_valid && (!req_dma || DMA_OK);
  wire logic stb_min_met = cnt_done;
  wire logic sel_min_met = (sel_cnt_q >= pick(speed_q, SLOW_SEL, FAST_SEL)) ; // [RL13]
  wire logic can_release = stb_min_met && ready_n_s; // [RL2] [RL17]
  wire logic leaving = (state_q == EEB_STROBE) && can_release;
  wire logic [3:0] lead_cyc = pick(speed_q, SLOW_LEAD, FAST_LEAD);
  wire logic [3:0] stb_cyc = pick(speed_q, SLOW_STB, FAST_STB) - 4'd1;
  wire logic [3:0] trail_cyc = lead_cyc;
  assign cnt_load = (state_q != state_d);
  assign cnt_value = (state_d == EEB_SETUP) ? SETUP - 4'd1 :
                     (state_d == EEB_LEAD) ? lead_cyc - 4'd1 :
                     (state_d == EEB_STROBE) ? stb_cyc :
                     (state_d == EEB_TRAIL) ? trail_cyc - 4'd1 :
                     (state_d == EEB_HOLD) ? HOLD - 4'd1 : 4'd0;

  // next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      EEB_IDLE: if (take) state_d = EEB_SETUP;
      EEB_SETUP: if (cnt_done) state_d = EEB_LEAD;
      EEB_LEAD: if (cnt_done) state_d = EEB_STROBE;
      EEB_STROBE: if (can_release) state_d = EEB_TRAIL;
      EEB_TRAIL: if (cnt_done && sel_min_met) state_d = EEB_HOLD;
      EEB_HOLD: if (cnt_done) state_d = EEB_IDLE;
      default: state_d = EEB_IDLE;
    endcase
  end

  // state and request capture
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state_q <= EEB_IDLE;
      kind_q <= EEB_KIND_EXT;
      speed_q <= EEB_SPEED_SLOW;
      read_q <= 1'b0;
      last_q <= 1'b0;
      wdata_q <= 32'h0;
    end else begin
      state_q <= state_d;
      if (take) begin
        kind_q <= req_dma ? EEB_KIND_DMA : EEB_KIND_EXT;
        speed_q <= req_fast ? EEB_SPEED_FAST : EEB_SPEED_SLOW;
        read_q <= req_read;
        last_q <= req_dma && req_last;
        wdata_q <= req_wdata;
      end
    end
  end

  // select-active cycle count for minimum width
  always_ff @(posedge ref_clk) begin
    if (!rstn) sel_cnt_q <= 4'h0;
    else if (state_q == EEB_LEAD || state_q == EEB_STROBE || state_q == EEB_TRAIL) begin
      if (sel_cnt_q != 4'hf) sel_cnt_q <= sel_cnt_q + 4'h1;
    end else sel_cnt_q <= 4'h0;
  end

  // address, width and direction held from setup through hold
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      addr_q <= 24'h0;
      bw_n_q <= 1'b1;
      rnw_q <= 1'b1;
    end else if (take) begin
      addr_q <= req_addr; // [RL14]
      bw_n_q <= req_dma ? 1'b1 : !req_byte; // [RL1]
      rnw_q <= req_read; // [RL7]
    end
  end

  // strobes, select and DMA outputs
  wire logic active = (state_d == EEB_LEAD) || (state_d == EEB_STROBE) || (state_d == EEB_TRAIL);
  wire logic dma_cyc = (kind_q == EEB_KIND_DMA);
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      sel_n_q <= 1'b1;
      ack_n_q <= 1'b1;
      tc_q <= 1'b0;
      wr_n_q <= 1'b1;
      rd_n_q <= 1'b1;
    end else begin
      sel_n_q <= !(active && !dma_cyc); // [RL10]
      ack_n_q <= !(active && dma_cyc && DMA_OK); // [RL5] [RL16]
      tc_q <= active && dma_cyc && last_q && DMA_OK; // [RL6]
      wr_n_q <= !(state_d == EEB_STROBE && !read_q); // [RL8]
      rd_n_q <= !(state_d == EEB_STROBE && read_q); // [RL9]
    end
  end

  // data lines: upper half released on reads of either kind
  wire logic busy_d = (state_d != EEB_IDLE);
  always_ff @(posedge ref_clk) begin
    if (!rstn) oe_q <= 2'b10;
    else begin
      oe_q[1] <= !(busy_d && read_q); // [RL11]
      oe_q[0] <= busy_d && !read_q;
    end
  end

  // capture read data as the strobe rises, completion pulse
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rdata_q <= 32'h0;
      rsp_q <= 1'b0;
    end else begin
      if (leaving && read_q) rdata_q <= data_s;
      rsp_q <= (state_q == EEB_HOLD) && cnt_done;
    end
  end

  // idle flag registered so that the request handshake comes from a flip-flop
  always_ff @(posedge ref_clk) begin
    if (!rstn) ready_q <= 1'b1;
    else ready_q <= (state_d == EEB_IDLE);
  end

  // reference clock out at half the system rate
  always_ff @(posedge ref_clk) begin
    if (!rstn) clk_q <= 1'b0;
    else clk_q <= !clk_q;
  end

  assign req_ready = ready_q;
  assign rsp_valid = rsp_q;
  assign rsp_rdata = rdata_q;
  assign dma_pending = treq_s && DMA_OK; // [RL4]
  assign latched_address = addr_q;
  assign byte_width_qualifier_n = bw_n_q;
  assign read_not_write = rnw_q;
  assign buffered_data_o = wdata_q;
  assign buffered_data_oe = oe_q;
  assign write_strobe_n = wr_n_q;
  assign read_strobe_n = rd_n_q;
  assign extended_space_select_n = sel_n_q;
  assign transfer_acknowledge_n = ack_n_q;
  assign last_transfer_flag = tc_q;
  assign host_system_clock = clk_q;

  // checks
  wire logic slot_on = !sel_n_q || !ack_n_q; // select or acknowledge out
  sel_strobe_order_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    $rose(extended_space_select_n) |-> $past(read_strobe_n) && $past(write_strobe_n)) // [RL17]
    else $error("select released while strobe active");
  wait_holds_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (state_q == EEB_STROBE && !ready_n_s) |=> (state_q == EEB_STROBE)) // [RL2]
    else $error("cycle ended during wait");
  strobe_width_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    $fell(read_strobe_n) && speed_q == EEB_SPEED_SLOW |-> !read_strobe_n [*5]) // [RL13]
    else $error("slow strobe too short");
  sel_width_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    $fell(extended_space_select_n) && speed_q == EEB_SPEED_FAST |-> !extended_space_select_n [*4]) // [RL13]
    else $error("fast select too short");
  addr_stable_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !extended_space_select_n || $rose(extended_space_select_n) |-> $stable(latched_address)) // [RL14]
    else $error("address changed under select");
  dir_stable_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (!read_strobe_n || !write_strobe_n) |-> $stable(read_not_write) && (read_not_write == !read_strobe_n)) // [RL7]
    else $error("direction wrong during strobe");
  upper_release_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !read_strobe_n |-> !buffered_data_oe[1]) // [RL11]
    else $error("upper data driven during read");
  dma_slot_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !DMA_OK |-> transfer_acknowledge_n && !last_transfer_flag) // [RL16]
    else $error("DMA signals on unsupported slot");
  tc_with_ack_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    last_transfer_flag |-> !transfer_acknowledge_n) // [RL6]
    else $error("terminal count outside acknowledge");
  byte_qual_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    take && !req_dma |=> byte_width_qualifier_n == !$past(req_byte)) // [RL1]
    else $error("width qualifier wrong");
  ack_sel_excl_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [RL5]
    !transfer_acknowledge_n |-> extended_space_select_n)
    else $error("acknowledge and select low together");
  fast_wstb_width_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [RL13]
    $fell(write_strobe_n) && speed_q == EEB_SPEED_FAST |-> !write_strobe_n [*3])
    else $error("fast strobe too short");
  slow_sel_width_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [RL13]
    $fell(extended_space_select_n) && speed_q == EEB_SPEED_SLOW |-> !extended_space_select_n [*8] ##1 !extended_space_select_n)
    else $error("slow select too short");
  strobe_in_slot_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [RL10]
    (!read_strobe_n || !write_strobe_n) |-> slot_on)
    else $error("strobe outside select or acknowledge");
  slow_lead_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [RL10]
    ($fell(read_strobe_n) || $fell(write_strobe_n)) && speed_q == EEB_SPEED_SLOW |-> $past(slot_on, 2))
    else $error("slow strobe fell too soon");
  upper_idle_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [RL11]
    req_ready |-> buffered_data_oe[1])
    else $error("upper data released while idle");
  strobe_excl_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [RL9]
    !read_strobe_n |-> write_strobe_n)
    else $error("both strobes low");
endmodule : eeb_slot_ctrl
`default_nettype wire

// ---- rtl/eeb_consts.svh ----
// timing constants of the slot controller
`ifndef EEB_CONSTS_SVH
`define EEB_CONSTS_SVH
`define EEB_CLK_PERIOD_NS 50
`define EEB_SLOW_SEL_NS 427
`define EEB_SLOW_STB_NS 240
`define EEB_FAST_SEL_NS 175
`define EEB_FAST_STB_NS 115
`define EEB_SLOW_LEAD_NS 80
`define EEB_FAST_LEAD_NS 15
`define EEB_SETUP_NS 10
`define EEB_HOLD_NS 10
`define EEB_CEIL_CYC(ns) (((ns) + `EEB_CLK_PERIOD_NS - 1) / `EEB_CLK_PERIOD_NS)
`define EEB_SLOW_STB_CYC `EEB_CEIL_CYC(`EEB_SLOW_STB_NS)
`define EEB_FAST_STB_CYC `EEB_CEIL_CYC(`EEB_FAST_STB_NS)
`define EEB_SLOW_LEAD_CYC `EEB_CEIL_CYC(`EEB_SLOW_LEAD_NS)
`define EEB_FAST_LEAD_CYC `EEB_CEIL_CYC(`EEB_FAST_LEAD_NS)
`define EEB_SLOW_SEL_CYC `EEB_CEIL_CYC(`EEB_SLOW_SEL_NS)
`define EEB_FAST_SEL_CYC `EEB_CEIL_CYC(`EEB_FAST_SEL_NS)
`define EEB_SETUP_CYC `EEB_CEIL_CYC(`EEB_SETUP_NS)
`define EEB_HOLD_CYC `EEB_CEIL_CYC(`EEB_HOLD_NS)
`endif

// ---- rtl/eeb_pkg.sv ----
// types of the slot controller
package eeb_pkg;
  typedef enum logic [1:0] {EEB_KIND_EXT, EEB_KIND_DMA} eeb_kind_t;
  typedef enum logic {EEB_SPEED_SLOW, EEB_SPEED_FAST} eeb_speed_t;
  typedef enum logic [2:0] {EEB_IDLE, EEB_SETUP, EEB_LEAD, EEB_STROBE, EEB_TRAIL, EEB_HOLD} eeb_state_t;
endpackage : eeb_pkg

// ---- rtl/eeb_sync.sv ----
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module eeb_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic ref_clk, // system clock
  input wire logic rstn, // synchronous reset, active low
  input wire logic [W-1:0] d, // asynchronous input
  output logic [W-1:0] q // synchronised output
);
  logic [W-1:0] meta_q;
  // refuse an empty synchroniser
  if (W < 1) begin : g_w_check
    $error("eeb_sync: W must be at least 1");
  end
  // first stage feeds only the second
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      meta_q <= INIT;
      q <= INIT;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : eeb_sync
`default_nettype wire

// ---- rtl/eeb_counter.sv ----
// loadable down counter that flags zero
`timescale 1ns/1ps
`default_nettype none
module eeb_counter #(
  parameter int W = 4
) (
  input wire logic ref_clk, // system clock
  input wire logic rstn, // synchronous reset, active low
  input wire logic load, // load pulse
  input wire logic [W-1:0] value, // cycles to count
  output logic done // high when count reached zero
);
  logic [W-1:0] cnt_q;
  // refuse a counter too narrow to hold any count
  if (W < 1) begin : g_w_check
    $error("eeb_counter: W must be at least 1");
  end
  // count down after a load
  always_ff @(posedge ref_clk) begin
    if (!rstn) cnt_q <= '0;
    else if (load) cnt_q <= value;
    else if (cnt_q != '0) cnt_q <= cnt_q - 1'b1;
  end
  // zero flag from the register alone: the loader decides on it, so no path back
  assign done = (cnt_q == '0);
endmodule : eeb_counter
`default_nettype wire

// ---- tb/eeb_card_model.sv ----
// card model in a slot: wait stretching, DMA request and read data
`timescale 1ns/1ps
`default_nettype none
module eeb_card_model #(
  parameter logic [31:0] RD_DATA = 32'h5aa5_c33c
) (
  input wire logic card_clk, // card local clock
  input wire logic [3:0] wait_cycles, // card clocks to stretch by
  input wire logic dreq_cmd, // rising edge raises a DMA request
  input wire logic sel_n, // extended select
  input wire logic stb_n, // either strobe
  input wire logic ack_n, // DMA acknowledge
  input wire logic rnw, // direction
  output logic ready_n, // wait line
  output logic dreq, // DMA request
  output logic [31:0] card_dq // value the card puts on the data lines
);
  logic [3:0] wait_q = 4'h0;
  initial dreq = 1'b0;
  // stretch count runs on the card's own clock while the strobe is low
  always @(posedge card_clk) begin
    if (sel_n) wait_q <= wait_cycles;
    else if (!stb_n && wait_q != 4'h0) wait_q <= wait_q - 4'h1;
  end
  // wait is pulled as soon as select falls, so even a short strobe is caught
  assign ready_n = !(!sel_n && wait_q != 4'h0);
  // request rises on command and drops once the host acknowledges
  always @(posedge dreq_cmd or negedge ack_n) begin
    if (!ack_n) dreq <= 1'b0;
    else dreq <= 1'b1;
  end
  // data only on selected or acknowledged reads; elsewhere a pattern unlike the real value
  assign card_dq = (rnw && (!sel_n || !ack_n)) ? RD_DATA : ~RD_DATA;
endmodule : eeb_card_model
`default_nettype wire

// ---- tb/eeb_slot_ctrl_tb.sv ----
// testbench of the slot controller with a card model
`timescale 1ns/1ps
`default_nettype none
module eeb_slot_ctrl_tb;
  localparam logic [31:0] RDV = 32'h5aa5_c33c;
  logic ref_clk, card_clk, rstn, req_valid, req_dma, req_read, req_byte, req_fast, req_last, dreq_cmd;
  logic [23:0] req_addr, exp_addr, a_p;
  logic [31:0] req_wdata, rsp_rdata, buffered_data_o, card_dq, wr_seen;
  wire [31:0] buffered_data_i;
  logic [1:0] buffered_data_oe;
  logic [3:0] wait_cycles;
  logic req_ready, rsp_valid, dma_pending, byte_width_qualifier_n, read_not_write, write_strobe_n;
  logic read_strobe_n, extended_space_select_n, ready_n, transfer_request, transfer_acknowledge_n;
  logic last_transfer_flag;
  logic [23:0] latched_address;
  logic [7:0] sel_c, sel_w, stb_c, stb_w;
  logic ack_seen, tc_seen, oe_hi, rnw_s, nbw_s, exp_nbw, addr_bad, order_bad, wait_bad, sel_p;
  logic hsc, hsc_p, rst_p, clk_bad;
  int miscompares = 0;
  int num_checks = 0;
  wire stb_n = read_strobe_n & write_strobe_n;
  // each half of the data lines is resolved from the host enable
  assign buffered_data_i = {buffered_data_oe[1] ? buffered_data_o[31:16] : card_dq[31:16],
                            buffered_data_oe[0] ? buffered_data_o[15:0] : card_dq[15:0]};
  eeb_slot_ctrl #(.SLOT(0)) eeb_slot_ctrl_inst (.ref_clk(ref_clk), .rstn(rstn), .req_valid(req_valid),
    .req_ready(req_ready), .req_dma(req_dma), .req_read(req_read), .req_byte(req_byte), .req_fast(req_fast),
    .req_last(req_last), .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .dma_pending(dma_pending), .latched_address(latched_address),
    .byte_width_qualifier_n(byte_width_qualifier_n), .buffered_data_i(buffered_data_i),
    .buffered_data_o(buffered_data_o), .buffered_data_oe(buffered_data_oe), .read_not_write(read_not_write),
    .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
    .extended_space_select_n(extended_space_select_n), .ready_n(ready_n), .transfer_request(transfer_request),
    .transfer_acknowledge_n(transfer_acknowledge_n), .last_transfer_flag(last_transfer_flag),
    .host_system_clock(hsc));
  eeb_card_model #(.RD_DATA(RDV)) eeb_card_model_inst (.card_clk(card_clk), .wait_cycles(wait_cycles),
    .dreq_cmd(dreq_cmd), .sel_n(extended_space_select_n), .stb_n(stb_n), .ack_n(transfer_acknowledge_n),
    .rnw(read_not_write), .ready_n(ready_n), .dreq(transfer_request), .card_dq(card_dq));
  // clocks: system clock and an unrelated card clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    card_clk = 1'b0;
    #137;
    forever #200 card_clk = ~card_clk;
  end
  // bus monitor: widths, levels during the strobe, ordering and stability
  always @(posedge ref_clk) begin
    if ((!extended_space_select_n || !sel_p) && {latched_address, byte_width_qualifier_n} !== {exp_addr, exp_nbw})
      addr_bad = 1'b1;
    if (!extended_space_select_n && sel_p && a_p !== exp_addr) addr_bad = 1'b1;
    if (extended_space_select_n && !sel_p && !stb_n) order_bad = 1'b1;
    if (!extended_space_select_n) sel_c = sel_c + 8'h1;
    else if (sel_c != 8'h0) begin
      sel_w = sel_c;
      sel_c = 8'h0;
    end
    if (!stb_n) begin
      stb_c = stb_c + 8'h1;
      oe_hi = buffered_data_oe[1];
      rnw_s = read_not_write;
      nbw_s = byte_width_qualifier_n;
    end else if (stb_c != 8'h0) begin
      stb_w = stb_c;
      stb_c = 8'h0;
      wr_seen = buffered_data_i;
      if (!ready_n) wait_bad = 1'b1;
    end
    if (!transfer_acknowledge_n) ack_seen = 1'b1;
    if (last_transfer_flag) tc_seen = 1'b1;
    sel_p = extended_space_select_n;
    a_p = latched_address;
    // reference clock out must toggle on every system clock once out of reset
    if (rst_p && hsc === hsc_p) clk_bad = 1'b1;
    hsc_p = hsc;
    rst_p = rstn;
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // one access through the request port, waiting for completion
  task automatic access(input logic dma, rd, byt, fast, last, input logic [23:0] a, input logic [31:0] d);
    int n;
    {sel_c, sel_w, stb_c, stb_w} = '0;
    {ack_seen, tc_seen, addr_bad, order_bad, wait_bad, clk_bad} = '0;
    exp_addr = a;
    exp_nbw = !byt;
    chk("req_ready", 1, req_ready);
    {req_dma, req_read, req_byte, req_fast, req_last, req_addr, req_wdata} = {dma, rd, byt, fast, last, a, d};
    req_valid = 1'b1;
    @(posedge ref_clk);
    #2 req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 600) begin
      @(posedge ref_clk);
      #2 n++;
    end
    chk("rsp_valid", 1, rsp_valid);
    repeat (3) @(posedge ref_clk);
    #2;
  endtask : access
  task automatic test_slow_write;
    wait_cycles = 4'h0;
    access(0, 0, 1, 0, 0, 24'h12_3456, 32'hdead_beef);
    chk("sel_width_min", 1, sel_w >= 8'd9);
    chk("stb_width_min", 1, stb_w >= 8'd5);
    chk("write_data", 32'hdead_beef, wr_seen);
    chk("dir_write", 0, rnw_s);
    chk("width_byte", 0, nbw_s);
    chk("upper_driven", 1, oe_hi);
    chk("addr_stable", 0, addr_bad);
    chk("no_ack", 0, ack_seen);
    chk("sys_clk_toggle", 0, clk_bad);
    $display("test_slow_write done");
  endtask : test_slow_write
  task automatic test_fast_read_wait;
    wait_cycles = 4'h3;
    repeat (10) @(posedge ref_clk);
    #2 access(0, 1, 0, 1, 0, 24'hfe_dcba, 32'h0);
    chk("read_data", RDV, rsp_rdata);
    chk("dir_read", 1, rnw_s);
    chk("width_word", 1, nbw_s);
    chk("upper_released", 0, oe_hi);
    chk("stb_stretched", 1, stb_w >= 8'd16);
    chk("end_in_wait", 0, wait_bad);
    chk("stb_then_sel", 0, order_bad);
    chk("sel_width_min", 1, sel_w >= 8'd4);
    chk("addr_stable", 0, addr_bad);
    $display("test_fast_read_wait done");
  endtask : test_fast_read_wait
  task automatic test_fast_write;
    wait_cycles = 4'h0;
    repeat (10) @(posedge ref_clk);
    #2 access(0, 0, 0, 1, 0, 24'h00_0001, 32'h0123_4567);
    chk("sel_width_min", 1, sel_w >= 8'd4);
    chk("stb_width_min", 1, stb_w >= 8'd3);
    chk("write_data", 32'h0123_4567, wr_seen);
    chk("stb_then_sel", 0, order_bad);
    $display("test_fast_write done");
  endtask : test_fast_write
  task automatic dma_req;
    int n;
    dreq_cmd = 1'b1;
    n = 0;
    while (dma_pending !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      #2 n++;
    end
    dreq_cmd = 1'b0;
    chk("dma_pending", 1, dma_pending);
  endtask : dma_req
  task automatic test_dma_read_last;
    dma_req();
    access(1, 1, 0, 0, 1, 24'h00_0100, 32'h0);
    chk("ack_low", 1, ack_seen);
    chk("tc_high", 1, tc_seen);
    chk("no_select", 0, sel_w);
    chk("upper_released", 0, oe_hi);
    chk("read_data", RDV, rsp_rdata);
    chk("req_dropped", 0, transfer_request);
    $display("test_dma_read_last done");
  endtask : test_dma_read_last
  task automatic test_dma_write;
    dma_req();
    access(1, 0, 0, 1, 0, 24'h00_0200, 32'hcafe_f00d);
    chk("ack_low", 1, ack_seen);
    chk("tc_low", 0, tc_seen);
    chk("upper_driven", 1, oe_hi);
    chk("write_data", 32'hcafe_f00d, wr_seen);
    chk("dir_write", 0, rnw_s);
    $display("test_dma_write done");
  endtask : test_dma_write
  task automatic wrap_up;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  // watchdog: the whole run needs well under 3000 cycles
  initial begin
    #(3000 * 50);
    miscompares++;
    wrap_up();
  end
  initial begin
    {rstn, req_valid, req_dma, req_read, req_byte, req_fast, req_last, dreq_cmd} = '0;
    {req_addr, req_wdata, wait_cycles, exp_addr, a_p, exp_nbw, sel_p} = '0;
    repeat (8) @(posedge ref_clk);
    #2 rstn = 1'b1;
    test_slow_write();
    test_fast_read_wait();
    test_fast_write();
    test_dma_read_last();
    test_dma_write();
    wrap_up();
  end
endmodule : eeb_slot_ctrl_tb
`default_nettype wire
